// ---- dual_counter_capture_timer.sv ----
/*
 * Two instances of a dual 16-bit down-counter timer with capture,
 * reload, square-wave output and four pending interrupt sources,
 * behind one AXI4-Lite slave.
 * Assumes pins A and B arrive asynchronously and the bus runs on
 * sys_clk_in.
 */
`timescale 1ns/10ps

module dual_counter_capture_timer
    import timer_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic [31:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [31:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic [1:0]  pin_a_in,
    output logic [1:0]       pin_a_out,
    output logic [1:0]       pin_a_oe_out,
    input  wire logic [1:0]  pin_b_in,
    output logic [1:0]       irq_line_a_out,
    output logic [1:0]       irq_line_b_out
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [1:0] inst_hit(input logic [31:0] a);
        return {a[31:12] == BASE_TWO[31:12], a[31:12] == BASE_ONE[31:12]};
    endfunction : inst_hit

    function automatic logic ofs_ok(input logic [31:0] a);
        return (a[11:0] <= OFS_ICLR) && (a[1:0] == 2'h0);
    endfunction : ofs_ok

    function automatic logic [1:0] resp_of(input logic [31:0] a);
        if (inst_hit(a) == 2'h0)
            return RESP_DECERR;
        return ofs_ok(a) ? RESP_OKAY : RESP_SLVERR;
    endfunction : resp_of

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0]  strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (val & m);
    endfunction : merge

    function automatic logic clk_tick(input logic [2:0] sel,
                                      input logic       presc,
                                      input logic       bev,
                                      input logic       blevel);
        unique case (sel)
            CK_PRESC: return presc;
            CK_EXT:   return bev;
            CK_PACC:  return presc & blevel;
            default:  return 1'b0;
        endcase
    endfunction : clk_tick

    ////////////////////////////////////////////////////////////////////////
    // State

    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, rd_word;
    logic [31:0] aw_addr, w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    logic [1:0]  wr_hit;

    logic [15:0]        cnt1 [2];
    logic [15:0]        cnt2 [2];
    logic [15:0]        cra  [2];
    logic [15:0]        crb  [2];
    logic [7:0]         prsc [2];
    logic [7:0]         pre_cnt [2];
    logic [5:0]         ckc  [2];
    logic [MC_BITS-1:0] mctrl [2];
    logic [3:0]         ien  [2];
    logic [3:0]         pend [2];
    logic [3:0]         ev   [2];
    logic [1:0]         outa, phase;
    logic [1:0]         pa_s1, pa_s2, pa_prev, pb_s1, pb_s2, pb_prev;
    logic [1:0]         en, t1, t2, uf1, uf2, capa, capb, edge_a, edge_b;
    logic [2:0]         mode [2];

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data in either order

    assign wr_go = ~awready & ~wready & ~bvalid;

    always_comb begin
        wr_hit = '0;
        if (wr_go && ofs_ok(aw_addr))
            wr_hit = inst_hit(aw_addr);
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end else begin
            if (s_axi_awvalid_in && awready) begin
                aw_addr <= s_axi_awaddr_in;
                awready <= 1'b0;
            end
            if (s_axi_wvalid_in && wready) begin
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
                wready <= 1'b0;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= resp_of(aw_addr);
            end
            if (bvalid && s_axi_bready_in) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    always_comb begin
        logic [1:0] hit;
        logic       i;
        hit = inst_hit(s_axi_araddr_in);
        i = hit[1];
        rd_word = '0;
        if (ofs_ok(s_axi_araddr_in) && inst_hit(s_axi_araddr_in) != 2'h0) begin
            unique case (s_axi_araddr_in[11:0])
                OFS_CNT1:  rd_word = {16'h0000, cnt1[i]};
                OFS_CRA:   rd_word = {16'h0000, cra[i]};
                OFS_CRB:   rd_word = {16'h0000, crb[i]};
                OFS_CNT2:  rd_word = {16'h0000, cnt2[i]};
                OFS_PRSC:  rd_word = {24'h000000, prsc[i]};
                OFS_CKC:   rd_word = {26'h0000000, ckc[i]};
                OFS_MCTRL: rd_word = {22'h000000, mctrl[i][9:8], outa[i],
                                      mctrl[i][6:0]};
                OFS_ICTRL: rd_word = {24'h000000, pend[i], ien[i]};
                default:   rd_word = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rresp   <= RESP_OKAY;
            rdata   <= '0;
        end else if (s_axi_arvalid_in && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= resp_of(s_axi_araddr_in);
            rdata   <= rd_word;
        end else if (rvalid && s_axi_rready_in) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pa_s1   <= '0;
            pa_s2   <= '0;
            pa_prev <= '0;
            pb_s1   <= '0;
            pb_s2   <= '0;
            pb_prev <= '0;
        end else begin
            pa_s1   <= pin_a_in;
            pa_s2   <= pa_s1;
            pa_prev <= pa_s2;
            pb_s1   <= pin_b_in;
            pb_s2   <= pb_s1;
            pb_prev <= pb_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 2; i++) begin
                prsc[i]  <= '0;
                ckc[i]   <= '0;
                mctrl[i] <= '0;
                ien[i]   <= '0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_hit[i] && aw_addr[11:0] == OFS_PRSC)
                    prsc[i] <= 8'(merge({24'h0, prsc[i]}, w_data, w_strb));
                if (wr_hit[i] && aw_addr[11:0] == OFS_CKC)
                    ckc[i] <= 6'(merge({26'h0, ckc[i]}, w_data, w_strb));
                if (wr_hit[i] && aw_addr[11:0] == OFS_MCTRL)
                    mctrl[i] <= MC_BITS'(merge({22'h0, mctrl[i]}, w_data, w_strb));
                if (wr_hit[i] && aw_addr[11:0] == OFS_ICTRL && w_strb[0])
                    ien[i] <= w_data[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event decode per instance

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            mode[i]   = mctrl[i][MC_MODE_LSB +: 3];
            en[i]     = mctrl[i][MC_EN];
            edge_a[i] = mctrl[i][MC_AEDG] ? (~pa_s2[i] & pa_prev[i])
                                          : (pa_s2[i] & ~pa_prev[i]);
            edge_b[i] = mctrl[i][MC_BEDG] ? (~pb_s2[i] & pb_prev[i])
                                          : (pb_s2[i] & ~pb_prev[i]);
            t1[i] = en[i] & clk_tick(ckc[i][CK1_LSB +: 3], pre_cnt[i] == prsc[i],
                    edge_b[i] & ~(mode[i] == MODE_1A & mctrl[i][MC_PTSE]),
                    pb_s2[i]);
            t2[i] = en[i] & clk_tick(ckc[i][CK2_LSB +: 3], pre_cnt[i] == prsc[i],
                    edge_b[i] & ~(mode[i] == MODE_1A & mctrl[i][MC_PTSE]),
                    pb_s2[i]);
            if (mode[i] == MODE_2 && ckc[i][CK1_LSB + 1])
                t1[i] = 1'b0;
            if (mode[i] == MODE_4 && ckc[i][CK2_LSB + 1])
                t2[i] = 1'b0;
            uf1[i]  = t1[i] & (cnt1[i] == ZERO16);
            uf2[i]  = t2[i] & (cnt2[i] == ZERO16);
            capa[i] = en[i] & (mode[i] == MODE_2) & edge_a[i];
            capb[i] = en[i] & (mode[i] == MODE_2 | mode[i] == MODE_4)
                    & edge_b[i];
            // Sources per mode
            ev[i][FLAG_A] = (mode[i] == MODE_2) ? capa[i]
                          : uf1[i] & ~phase[i];
            ev[i][FLAG_B] = (mode[i] == MODE_2 | mode[i] == MODE_4) ? capb[i]
                          : (mode[i] == MODE_3) ? 1'b0
                          : uf1[i] & phase[i];
            ev[i][FLAG_C] = (mode[i] == MODE_2) & uf1[i];
            ev[i][FLAG_D] = uf2[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters, capture/reload registers and output A

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 2; i++) begin
                cnt1[i]    <= '0;
                cnt2[i]    <= '0;
                cra[i]     <= '0;
                crb[i]     <= '0;
                pre_cnt[i] <= '0;
            end
            outa  <= '0;
            phase <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!en[i] || pre_cnt[i] == prsc[i])
                    pre_cnt[i] <= '0;
                else
                    pre_cnt[i] <= pre_cnt[i] + 8'h01;

                if (wr_hit[i] && aw_addr[11:0] == OFS_CNT1 && en[i])
                    cnt1[i] <= 16'(merge({16'h0, cnt1[i]}, w_data, w_strb));
                else if ((capa[i] & mctrl[i][MC_AEN]) |
                         (capb[i] & mode[i] == MODE_2 & mctrl[i][MC_BEN]))
                    cnt1[i] <= PRESET_VALUE;
                else if (uf1[i] && mode[i] != MODE_2)
                    cnt1[i] <= phase[i] ? crb[i] : cra[i];
                else if (t1[i])
                    cnt1[i] <= cnt1[i] - ONE16;

                if (wr_hit[i] && aw_addr[11:0] == OFS_CNT2 && en[i])
                    cnt2[i] <= 16'(merge({16'h0, cnt2[i]}, w_data, w_strb));
                else if (capb[i] && mode[i] == MODE_4 && mctrl[i][MC_BEN])
                    cnt2[i] <= PRESET_VALUE;
                else if (uf2[i] && mode[i] == MODE_3)
                    cnt2[i] <= crb[i];
                else if (uf2[i] && mode[i] == MODE_1A)
                    cnt2[i] <= ZERO16;
                else if (t2[i])
                    cnt2[i] <= cnt2[i] - ONE16;

                if (wr_hit[i] && aw_addr[11:0] == OFS_CRA && en[i])
                    cra[i] <= 16'(merge({16'h0, cra[i]}, w_data, w_strb));
                else if (capa[i])
                    cra[i] <= cnt1[i];

                if (wr_hit[i] && aw_addr[11:0] == OFS_CRB && en[i])
                    crb[i] <= 16'(merge({16'h0, crb[i]}, w_data, w_strb));
                else if (capb[i])
                    crb[i] <= (mode[i] == MODE_4) ? cnt2[i] : cnt1[i];

                if (uf1[i] && mctrl[i][MC_AEN] && mode[i] != MODE_2)
                    outa[i] <= ~outa[i];
                else if (wr_hit[i] && aw_addr[11:0] == OFS_MCTRL && w_strb[0])
                    outa[i] <= w_data[MC_AOUT];

                if (!en[i] || (mode[i] != MODE_1 && mode[i] != MODE_1A))
                    phase[i] <= 1'b0;
                else if (uf1[i])
                    phase[i] <= ~phase[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending flags and interrupt lines

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 2; i++)
                pend[i] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_hit[i] && aw_addr[11:0] == OFS_ICLR && w_strb[0])
                    pend[i] <= (pend[i] & ~w_data[3:0]) | ev[i];
                else
                    pend[i] <= pend[i] | ev[i];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_line_a_out <= '0;
            irq_line_b_out <= '0;
            pin_a_out      <= '0;
            pin_a_oe_out   <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                irq_line_a_out[i] <= |(pend[i][2:0] & ien[i][2:0]);
                irq_line_b_out[i] <= pend[i][FLAG_D] & ien[i][FLAG_D];
                pin_a_out[i]      <= outa[i];
                pin_a_oe_out[i]   <= mctrl[i][MC_AEN] & (mode[i] != MODE_2);
            end
        end
    end

    assign s_axi_awready_out = awready;
    assign s_axi_wready_out  = wready;
    assign s_axi_bvalid_out  = bvalid;
    assign s_axi_bresp_out   = bresp;
    assign s_axi_arready_out = arready;
    assign s_axi_rvalid_out  = rvalid;
    assign s_axi_rresp_out   = rresp;
    assign s_axi_rdata_out   = rdata;

    ////////////////////////////////////////////////////////////////////////
    // Assertions on instance one

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_capture_b;
        capb[0] && mode[0] == MODE_4 && !wr_hit[0];
    endsequence

    sequence s_preset_seen;
        crb[0] == $past(cnt2[0]) && cnt2[0] == PRESET_VALUE;
    endsequence

    a_cnt1_reload: assert property ((uf1[0] && mode[0] == MODE_4 && !wr_hit[0])
        |=> cnt1[0] == $past(cra[0])) else $error("counter one missed reload");
    a_out_toggle: assert property ((uf1[0] && mctrl[0][MC_AEN] && mode[0] == MODE_4)
        |=> outa[0] != $past(outa[0]) ##1 pin_a_out[0] == $past(outa[0]))
        else $error("output A did not toggle");
    a_flag_a_set: assert property ((uf1[0] && mode[0] == MODE_4)
        |=> pend[0][FLAG_A]) else $error("flag A not set on reload");
    a_capture_b: assert property (s_capture_b
        |=> crb[0] == $past(cnt2[0]) && pend[0][FLAG_B]) else $error("capture B lost");
    a_preset_cnt2: assert property ((s_capture_b and mctrl[0][MC_BEN])
        |=> s_preset_seen) else $error("preset after capture failed");
    a_flag_d_set: assert property (uf2[0]
        |=> pend[0][FLAG_D]) else $error("flag D not set on underflow");
    a_edge_select: assert property (capb[0]
        |-> pb_s2[0] == !mctrl[0][MC_BEDG]) else $error("wrong capture edge");
    a_cnt2_halt: assert property ((mode[0] == MODE_4 && ckc[0][CK2_LSB + 1]
        && !capb[0] && !wr_hit[0]) |=> $stable(cnt2[0])) else $error("counter two ran");
    a_write_ignored: assert property ((wr_hit[0] && aw_addr[11:0] == OFS_CNT1
        && !en[0]) |=> $stable(cnt1[0])) else $error("counter write not ignored");
    a_irq_line_a: assert property (|(pend[0][2:0] & ien[0][2:0])
        |=> irq_line_a_out[0]) else $error("line A not raised");

endmodule : dual_counter_capture_timer

// ---- dual_counter_capture_timer_tb_top.sv ----
/*
 * Self-checking bench for the dual counter capture timer: AXI4-Lite
 * master tasks, a response monitor fed by an expectation queue, pin model.
 * Assumes a 10 MHz clock and the register map of timer_pkg.
 */
`timescale 1ns/10ps
module dual_counter_capture_timer_tb_top;
    import timer_pkg::*;
    logic        sys_clk_in, rstn_in, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, last_a;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0]  bresp, rresp, pin_a, pin_a_oe, pin_a_drv, pin_b_drv, irq_a, irq_b;
    logic [33:0] exp_q[$];
    logic [7:0]  gap;
    logic [3:0]  wstrb;
    logic [15:0] rnd;
    int          n_errors, total_checks, toggles;

    dual_counter_capture_timer u_dual_counter_capture_timer (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pin_a_in(pin_a_drv),
        .pin_a_out(pin_a), .pin_a_oe_out(pin_a_oe), .pin_b_in(pin_b_drv),
        .irq_line_a_out(irq_a), .irq_line_b_out(irq_b));
    pin_source_model u_pin_source_model (
        .clk_in(sys_clk_in), .pin_a_drv_out(pin_a_drv), .pin_b_drv_out(pin_b_drv));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [31:0] r1(input logic [11:0] o);
        return BASE_ONE | {20'h0, o};
    endfunction : r1
    function automatic logic [31:0] r2(input logic [11:0] o);
        return BASE_TWO | {20'h0, o};
    endfunction : r2

    task check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task final_report;
        $display("Checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        int i;
        exp_q.push_back({RESP_OKAY, 32'h0});
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk_in);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        if (i == 50) begin
            n_errors++;
            final_report();
        end
        @(posedge sys_clk_in);
    endtask : wr

    task rd(input logic [31:0] a, input logic [33:0] exp);
        int i;
        exp_q.push_back(exp);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk_in);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        if (i == 50) begin
            n_errors++;
            final_report();
        end
        @(posedge sys_clk_in);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_in) begin
        if (rvalid === 1'b1 && rready === 1'b1)
            check("rdata", {rresp, rdata}, exp_q.pop_front());
        if (bvalid === 1'b1 && bready === 1'b1)
            check("bresp", {bresp, 32'h0}, exp_q.pop_front());
    end

    // Spacing of output A changes once free running
    always @(posedge sys_clk_in) begin
        gap <= gap + 8'h01;
        if (pin_a[0] !== last_a) begin
            last_a  <= pin_a[0];
            gap     <= 8'h01;
            toggles <= toggles + 1;
            if (toggles >= 2) check("toggle_gap", {26'h0, gap}, 34'h4);
        end
    end

    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    initial begin
        {rstn_in, awvalid, wvalid, bready, arvalid, rready, last_a} = 7'h00;
        {awaddr, wdata, araddr, wstrb} = 100'h0;
        {n_errors, total_checks, toggles, gap} = '0;
        rnd = lfsr(16'h0058);
        repeat (4) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        @(posedge sys_clk_in);
        rd(r1(OFS_MCTRL), {RESP_OKAY, 32'h0});
        rd(r1(12'h024), {RESP_SLVERR, 32'h0});
        rd(32'h40f0_0000, {RESP_DECERR, 32'h0});
        wr(r1(OFS_CNT1), 32'h5);
        rd(r1(OFS_CNT1), {RESP_OKAY, 32'h0});
        wr(r1(OFS_MCTRL), 32'h1e4);
        repeat (2) @(posedge sys_clk_in);
        check("pin_a", {32'h0, pin_a_oe[0], pin_a[0]}, 34'h3);
        wr(r1(OFS_ICTRL), 32'hb);
        wr(r1(OFS_CRA), 32'h3);
        wr(r1(OFS_CNT2), {16'h0, rnd});
        wr(r1(OFS_PRSC), 32'h0);
        wr(r1(OFS_CKC), 32'h11);
        repeat (20) @(posedge sys_clk_in);
        rd(r1(OFS_CNT2), {RESP_OKAY, 16'h0, rnd});
        rd(r1(OFS_ICTRL), {RESP_OKAY, 32'h1b});
        check("irq", {32'h0, irq_a[0], irq_b[0]}, 34'h2);
        u_pin_source_model.set_b(0, 1'b1);
        repeat (2) @(posedge sys_clk_in);
        u_pin_source_model.set_b(0, 1'b0);
        repeat (8) @(posedge sys_clk_in);
        rd(r1(OFS_CRB), {RESP_OKAY, 16'h0, rnd});
        rd(r1(OFS_CNT2), {RESP_OKAY, 32'hffff});
        wr(r1(OFS_CNT2), 32'h2);
        wr(r1(OFS_CKC), 32'h08);
        repeat (8) @(posedge sys_clk_in);
        wr(r1(OFS_ICLR), 32'hf, 4'he);
        rd(r1(OFS_ICTRL), {RESP_OKAY, 32'hbb});
        check("irq_b", {33'h0, irq_b[0]}, 34'h1);
        wr(r1(OFS_ICLR), 32'hf);
        rd(r1(OFS_ICTRL), {RESP_OKAY, 32'h0b});
        check("irq_clr", {32'h0, irq_a[0], irq_b[0]}, 34'h0);
        wr(r2(OFS_MCTRL), 32'h114);
        wr(r2(OFS_CNT2), 32'h1234);
        check("oe_two", {33'h0, pin_a_oe[1]}, 34'h0);
        u_pin_source_model.set_b(1, 1'b1);
        repeat (8) @(posedge sys_clk_in);
        rd(r2(OFS_CRB), {RESP_OKAY, 32'h0});
        u_pin_source_model.set_b(1, 1'b0);
        repeat (8) @(posedge sys_clk_in);
        rd(r2(OFS_CRB), {RESP_OKAY, 32'h1234});
        wr(r2(OFS_MCTRL), 32'h122);
        wr(r2(OFS_CNT1), 32'h55);
        u_pin_source_model.set_a(1, 1'b1);
        repeat (8) @(posedge sys_clk_in);
        check("oe_mode2", {33'h0, pin_a_oe[1]}, 34'h0);
        rd(r2(OFS_CRA), {RESP_OKAY, 32'h55});
        rd(r2(OFS_CNT1), {RESP_OKAY, 32'hffff});
        rd(r2(OFS_ICTRL), {RESP_OKAY, 32'h30});
        final_report();
    end
endmodule : dual_counter_capture_timer_tb_top

// ---- pin_source_model.sv ----
/*
 * Far-side model of the signals wired to pins A and B of both instances.
 * Assumes the bench calls set_a or set_b just after a rising clock edge.
 */
`timescale 1ns/10ps
module pin_source_model (
    input  wire logic       clk_in,
    output logic [1:0]      pin_a_drv_out,
    output logic [1:0]      pin_b_drv_out
);
    initial begin
        pin_a_drv_out = 2'h0;
        pin_b_drv_out = 2'h0;
    end

    // A level stands until the next call, so every pulse spans whole clocks
    task set_b(input int idx, input logic val);
        @(posedge clk_in);
        pin_b_drv_out[idx] <= val;
    endtask : set_b

    task set_a(input int idx, input logic val);
        @(posedge clk_in);
        pin_a_drv_out[idx] <= val;
    endtask : set_a
endmodule : pin_source_model

// ---- timer_pkg.sv ----
/*
 * Constants shared by the dual counter capture timer: decode bases,
 * register offsets, field positions, mode and clock-select codes,
 * and AXI4-Lite response codes.
 * Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package timer_pkg;

    localparam int          CLK_FREQ_HZ   = 10_000_000;

    // Instance bases; bits 31:12 decode the instance
    localparam logic [31:0] BASE_ONE      = 32'h40d0_0000;
    localparam logic [31:0] BASE_TWO      = 32'h40e0_0000;

    // Register offsets
    localparam logic [11:0] OFS_CNT1      = 12'h000;
    localparam logic [11:0] OFS_CRA       = 12'h004;
    localparam logic [11:0] OFS_CRB       = 12'h008;
    localparam logic [11:0] OFS_CNT2      = 12'h00c;
    localparam logic [11:0] OFS_PRSC      = 12'h010;
    localparam logic [11:0] OFS_CKC       = 12'h014;
    localparam logic [11:0] OFS_MCTRL     = 12'h018;
    localparam logic [11:0] OFS_ICTRL     = 12'h01c;
    localparam logic [11:0] OFS_ICLR      = 12'h020;

    // Mode control fields
    localparam int          MC_MODE_LSB   = 0;
    localparam int          MC_AEDG       = 3;
    localparam int          MC_BEDG       = 4;
    localparam int          MC_AEN        = 5;
    localparam int          MC_BEN        = 6;
    localparam int          MC_AOUT       = 7;
    localparam int          MC_EN         = 8;
    localparam int          MC_PTSE       = 9;
    localparam int          MC_BITS       = 10;

    localparam logic [2:0]  MODE_1        = 3'h0;
    localparam logic [2:0]  MODE_1A       = 3'h1;
    localparam logic [2:0]  MODE_2        = 3'h2;
    localparam logic [2:0]  MODE_3        = 3'h3;
    localparam logic [2:0]  MODE_4        = 3'h4;

    // Clock select fields and codes
    localparam int          CK1_LSB       = 0;
    localparam int          CK2_LSB       = 3;
    localparam logic [2:0]  CK_NONE       = 3'h0;
    localparam logic [2:0]  CK_PRESC      = 3'h1;
    localparam logic [2:0]  CK_EXT        = 3'h2;
    localparam logic [2:0]  CK_PACC       = 3'h3;

    // Interrupt control: enables in 3:0, pending flags in 7:4
    localparam int          IC_PEND_LSB   = 4;
    localparam int          FLAG_A        = 0;
    localparam int          FLAG_B        = 1;
    localparam int          FLAG_C        = 2;
    localparam int          FLAG_D        = 3;

    localparam logic [15:0] PRESET_VALUE  = 16'hffff;
    localparam logic [15:0] ZERO16        = 16'h0000;
    localparam logic [15:0] ONE16         = 16'h0001;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [1:0]  RESP_DECERR   = 2'h3;

endpackage : timer_pkg
